// >>> src/kms_scanner.sv
// Keypad matrix scanner: registers, keypad clock, scan sequencer.
// Assumes a register master on core_clk and raw keypad pins.
//
// Notes on behaviour
// - Status bit 3 reads keypad clock level.
// - Status bit 2 selects automatic or manual scanning.
// - Automatic scan sets flag, interrupts, stores location.
// - Manual: sense falling edge after all-high sets flag.
// - Reading control/status clears the flag.
// - Manual detect works without the keypad clock.
// - Enable bit gates interrupt only, not flag.
// - Size settings only matter in automatic mode.
// - Size bits 5:3 give sense lines scanned.
// - Size bits 2:0 give drive lines scanned.
// - Scan order: five three-bit drive-line slots.
// - Step slots first to fifth up to count.
// - Low order register holds slots one, two, part three.
// - Slot value selects drive line number directly.
// - Manual mode drives pins from drive-line register.
// - Presses and releases debounced in 4 ms steps.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module kms_scanner
   import kms_pkg::*;
#(
   parameter int HALF_CYCLES = KCLK_HALF_CYCLES
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Keypad clock run request from power control.
   input wire logic kclk_run,
   // Keypad pins.
   input wire logic [5:0] sense_in,
   output logic [4:0] drive_out,
   // Key-detect interrupt.
   output logic key_irq
);

   // Software registers.
   logic [4:0] drive_line_register_q; // Drive value or found column.
   logic [5:0] sense_line_register_q; // Sense value or found row.
   logic [7:0] timing_q; // Debounce and scan time codes.
   logic [5:0] keypad_size_q; // Sense and drive line counts.
   logic [7:0] scan_order_low_q; // Slots one, two, low of three.
   logic [6:0] scan_order_high_q; // Slot three msb, four, five.
   logic auto_scan_enable_q; // Automatic scan mode.
   logic key_found_flag_q; // Sticky key-detect flag.
   logic key_found_irq_enable_q; // Interrupt gate.
   // Keypad clock.
   logic [19:0] div_q; // Half-period counter.
   logic scan_clock_level_q; // Keypad clock level.
   logic tick; // One core cycle per keypad clock period.
   // Sense synchroniser and edge history.
   logic [5:0] sense_meta_q; // First stage, read only by the second.
   logic [5:0] sense_sync_q; // Second stage.
   logic [5:0] sense_prev_q; // Previous synchronised value.
   // Sequencer.
   kms_state_type state_q; // Scan state.
   logic [2:0] slot_q; // Current slot index.
   logic [8:0] timer_q; // Countdown in keypad clock periods.
   // Decoded helpers.
   logic wr_hit_status; // Write to control/status.
   logic rd_hit_status; // Read of control/status.
   logic [2:0] drive_count; // Effective drive-line count.
   logic [2:0] sense_count; // Effective sense-line count.
   logic [5:0] sense_mask; // Ones for sense lines in use.
   logic key_low; // A scanned sense line is low.
   logic [14:0] scan_order; // Full scan order value.
   logic [2:0] slot_line [0:4]; // Drive line named by each slot.
   logic [2:0] sel_line; // Drive line of the current slot.
   logic [4:0] scan_pattern; // Drive pattern for the current slot.
   logic [8:0] db_ticks; // Debounce length.
   logic [8:0] scan_ticks; // Settle time per slot.
   logic last_slot; // Current slot is the final one.
   logic auto_found; // Automatic detection event.
   logic manual_fall; // Manual detection event.
   logic flag_set; // Any detection event.

   // Register decodes.
   assign wr_hit_status = reg_wr && (reg_addr == OFF_STATUS);
   assign rd_hit_status = reg_rd && (reg_addr == OFF_STATUS);

   // Counts of zero or above the pin count mean all lines.
   always_comb begin
      drive_count = keypad_size_q[SIZE_DRIVE_LSB +: 3];
      sense_count = keypad_size_q[SIZE_SENSE_LSB +: 3];
      if ((drive_count == 3'h0) || (drive_count > MAX_DRIVE)) begin
         drive_count = MAX_DRIVE;
      end
      if ((sense_count == 3'h0) || (sense_count > MAX_SENSE)) begin
         sense_count = MAX_SENSE;
      end
   end

   // Slot three straddles both order registers.
   assign scan_order = {scan_order_high_q,
                        scan_order_low_q};

   // Split the order into slots and build masks per line.
   genvar g;
   generate
      for (g = 0; g < DRIVE_LINES; g++) begin : g_slot
         // Each slot names a drive line by number.
         assign slot_line[g] = scan_order[g*SLOT_BITS +: SLOT_BITS];
         // Only the named line goes low; a number above 4 drives none.
         assign scan_pattern[g] = (sel_line != 3'(g));
      end
      for (g = 0; g < SENSE_LINES; g++) begin : g_mask
         // Sense lines past the count are ignored.
         assign sense_mask[g] = (3'(g) < sense_count);
      end
   endgenerate

   assign sel_line = slot_line[slot_q];
   assign key_low = |(~sense_sync_q & sense_mask);
   assign last_slot = ({1'b0, slot_q} + 4'h1) >= {1'b0, drive_count};

   // Debounce code zero is the longest setting.
   always_comb begin
      db_ticks = {timing_q[TIM_DB_LSB +: 6] == 6'h0 ? DB_ZERO_STEPS :
                  {1'b0, timing_q[TIM_DB_LSB +: 6]}, 2'b00};
      scan_ticks = {7'h00, timing_q[TIM_SCAN_LSB +: 2]};
      if (timing_q[TIM_SCAN_LSB +: 2] == 2'h0) begin
         scan_ticks = {6'h00, SCAN_ZERO_MS};
      end
   end

   // Keypad clock divider; it stops when power control idles it.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         div_q <= 20'h00000;
         scan_clock_level_q <= 1'b0;
      end else if (!kclk_run) begin
         div_q <= 20'h00000;
      end else if (div_q >= 20'(HALF_CYCLES - 1)) begin
         div_q <= 20'h00000;
         scan_clock_level_q <= ~scan_clock_level_q;
      end else begin
         div_q <= div_q + 20'h00001;
      end
   end

   // One tick per period, at the rising half.
   assign tick = kclk_run && !scan_clock_level_q &&
                 (div_q >= 20'(HALF_CYCLES - 1));

   // Two-stage synchroniser for the sense pins, plus history.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sense_meta_q <= RST_SENSE;
         sense_sync_q <= RST_SENSE;
         sense_prev_q <= RST_SENSE;
      end else begin
         sense_meta_q <= sense_in;
         sense_sync_q <= sense_meta_q;
         sense_prev_q <= sense_sync_q;
      end
   end

   // Manual detect runs on the core clock alone, so a stopped keypad
   // clock does not mask a press. Bouncing keys may retrigger it.
   assign manual_fall = !auto_scan_enable_q && (&sense_prev_q) &&
                        !(&sense_sync_q);

   // Automatic detect fires when the press debounce ends still low.
   assign auto_found = auto_scan_enable_q && (state_q == ST_PRESS_DB) &&
                       tick && (timer_q <= 9'h001) && key_low;

   assign flag_set = auto_found || manual_fall;

   // Scan sequencer; it idles at the first slot in manual mode.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_q <= ST_SCAN;
         slot_q <= 3'h0;
         timer_q <= 9'h000;
      end else if (!auto_scan_enable_q) begin
         // Size settings have no effect here.
         state_q <= ST_SCAN;
         slot_q <= 3'h0;
         timer_q <= scan_ticks;
      end else begin
         case (state_q)
            ST_SCAN: begin
               // Settle, then sample the sense lines.
               if (tick) begin
                  if (timer_q > 9'h001) begin
                     timer_q <= timer_q - 9'h001;
                  end else if (key_low) begin
                     state_q <= ST_PRESS_DB;
                     timer_q <= db_ticks;
                  end else begin
                     slot_q <= last_slot ? 3'h0 : slot_q + 3'h1;
                     timer_q <= scan_ticks;
                  end
               end
            end
            ST_PRESS_DB: begin
               // A bounce back high abandons the press.
               if (tick) begin
                  if (!key_low) begin
                     state_q <= ST_SCAN;
                     timer_q <= scan_ticks;
                  end else if (timer_q > 9'h001) begin
                     timer_q <= timer_q - 9'h001;
                  end else begin
                     state_q <= ST_HOLD;
                  end
               end
            end
            ST_HOLD: begin
               // Wait for the key to let go.
               if (!key_low) begin
                  state_q <= ST_RELEASE_DB;
                  timer_q <= db_ticks;
               end
            end
            ST_RELEASE_DB: begin
               // Release must stay high for the full debounce.
               if (key_low) begin
                  state_q <= ST_HOLD;
               end else if (tick) begin
                  if (timer_q > 9'h001) begin
                     timer_q <= timer_q - 9'h001;
                  end else begin
                     state_q <= ST_SCAN;
                     slot_q <= last_slot ? 3'h0 : slot_q + 3'h1;
                     timer_q <= scan_ticks;
                  end
               end
            end
            default: begin
               state_q <= ST_SCAN;
               slot_q <= 3'h0;
               timer_q <= scan_ticks;
            end
         endcase
      end
   end

   // Control bits written by software.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         auto_scan_enable_q <= 1'b0;
         key_found_irq_enable_q <= 1'b0;
      end else if (wr_hit_status) begin
         auto_scan_enable_q <= reg_wdata[BIT_AUTO];
         key_found_irq_enable_q <= reg_wdata[BIT_IRQ_EN];
      end
   end

   // Sticky flag: a new event beats a clearing read in the same cycle.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         key_found_flag_q <= 1'b0;
      end else if (flag_set) begin
         key_found_flag_q <= 1'b1;
      end else if (rd_hit_status) begin
         key_found_flag_q <= 1'b0;
      end
   end

   // Interrupt follows the flag only while enabled.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         key_irq <= 1'b0;
      end else begin
         key_irq <= key_found_irq_enable_q &&
                    (flag_set || (key_found_flag_q && !rd_hit_status));
      end
   end

   // Timing, size and order registers.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         timing_q <= RST_TIMING;
         keypad_size_q <= RST_SIZE;
         scan_order_low_q <= RST_ORDER_LO;
         scan_order_high_q <= RST_ORDER_HI;
      end else if (reg_wr) begin
         case (reg_addr)
            OFF_TIMING: timing_q <= reg_wdata;
            OFF_SIZE: keypad_size_q <= reg_wdata[5:0];
            OFF_ORDER_LO: scan_order_low_q <= reg_wdata;
            OFF_ORDER_HI: scan_order_high_q <= reg_wdata[6:0];
            default: begin
            end
         endcase
      end
   end

   // Drive-line register: software value, or the found column.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         drive_line_register_q <= RST_DRIVE;
      end else if (auto_found) begin
         drive_line_register_q <= scan_pattern;
      end else if (reg_wr && (reg_addr == OFF_DRIVE)) begin
         drive_line_register_q <= reg_wdata[4:0];
      end
   end

   // Sense-line register: live pins in manual mode, found row otherwise.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sense_line_register_q <= RST_SENSE;
      end else if (!auto_scan_enable_q) begin
         sense_line_register_q <= sense_sync_q;
      end else if (auto_found) begin
         sense_line_register_q <= sense_sync_q | ~sense_mask;
      end
   end

   // Drive pins: the scan pattern, or the held register value.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         drive_out <= RST_DRIVE;
      end else if (auto_scan_enable_q) begin
         drive_out <= scan_pattern;
      end else begin
         drive_out <= drive_line_register_q;
      end
   end

   // Read data stand for one cycle after the strobe, else zero.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            OFF_DRIVE: reg_rdata <= {3'h0, drive_line_register_q};
            OFF_SENSE: reg_rdata <= {2'h0, sense_line_register_q};
            OFF_TIMING: reg_rdata <= timing_q;
            OFF_STATUS: begin
               // The flag reads as set on the read that clears it.
               reg_rdata <= {4'h0, scan_clock_level_q,
                             auto_scan_enable_q, key_found_flag_q,
                             key_found_irq_enable_q};
            end
            OFF_SIZE: reg_rdata <= {2'h0, keypad_size_q};
            OFF_ORDER_LO: reg_rdata <= scan_order_low_q;
            OFF_ORDER_HI: reg_rdata <= {1'b0, scan_order_high_q};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule : kms_scanner

// >>> src/kms_pkg.sv
// Constants shared by the keypad matrix scanner.
// Assumes an 8-bit register port and a 200 MHz core clock.
package kms_pkg;
   // Register offsets on the register port.
   localparam logic [7:0] OFF_DRIVE = 8'hd1;
   localparam logic [7:0] OFF_SENSE = 8'hd2;
   localparam logic [7:0] OFF_TIMING = 8'hd3;
   localparam logic [7:0] OFF_STATUS = 8'hd4;
   localparam logic [7:0] OFF_SIZE = 8'hd5;
   localparam logic [7:0] OFF_ORDER_LO = 8'hd6;
   localparam logic [7:0] OFF_ORDER_HI = 8'hd7;
   // Reset values.
   localparam logic [4:0] RST_DRIVE = 5'h1f;
   localparam logic [5:0] RST_SENSE = 6'h3f;
   localparam logic [7:0] RST_TIMING = 8'h00;
   localparam logic [5:0] RST_SIZE = 6'h00;
   localparam logic [7:0] RST_ORDER_LO = 8'h00;
   localparam logic [6:0] RST_ORDER_HI = 7'h00;
   // Control and status bit positions.
   localparam int BIT_IRQ_EN = 0;
   localparam int BIT_FLAG = 1;
   localparam int BIT_AUTO = 2;
   localparam int BIT_CLK = 3;
   // Size field positions.
   localparam int SIZE_DRIVE_LSB = 0;
   localparam int SIZE_SENSE_LSB = 3;
   // Timing field positions.
   localparam int TIM_SCAN_LSB = 0;
   localparam int TIM_DB_LSB = 2;
   // Line counts.
   localparam int DRIVE_LINES = 5;
   localparam int SENSE_LINES = 6;
   localparam int SLOT_BITS = 3;
   localparam logic [2:0] MAX_DRIVE = 3'h5;
   localparam logic [2:0] MAX_SENSE = 3'h6;
   // Debounce steps, in keypad clock periods, and the code-zero value.
   localparam logic [1:0] DB_STEP_SHIFT = 2'h2;
   localparam logic [6:0] DB_ZERO_STEPS = 7'h40;
   localparam logic [2:0] SCAN_ZERO_MS = 3'h4;
   // Keypad clock timing.
   localparam int CORE_PERIOD_PS = 5000;
   localparam int KCLK_PERIOD_US = 1000;
   localparam int KCLK_HALF_CYCLES =
      (KCLK_PERIOD_US * 1000000 / CORE_PERIOD_PS) / 2;
   // Scan sequencer states.
   typedef enum logic [1:0] {
      ST_SCAN = 2'b00,
      ST_PRESS_DB = 2'b01,
      ST_HOLD = 2'b10,
      ST_RELEASE_DB = 2'b11
   } kms_state_type;
endpackage : kms_pkg

// >>> verification/kms_keypad.sv
// Model of the switch matrix that sits on the drive and sense lines.
// Assumes the scanner selects a drive line by pulling it low.
`timescale 1ns/1ps
module kms_keypad (
   // Two keys held by the bench, key 1 in the upper fields.
   input wire logic [1:0] key_down,
   input wire logic [5:0] key_row,
   input wire logic [5:0] key_col,
   // Matrix lines.
   input wire logic [4:0] drive_out,
   output logic [5:0] sense_in
);
   // A closed switch ties its sense line to its drive line.
   // Pull-ups hold every other sense line, unused rows too, high.
   always_comb begin
      sense_in = 6'h3f;
      for (int k = 0; k < 2; k++) begin
         if (key_down[k] && drive_out[key_col[3*k +: 3]] === 1'b0) begin
            sense_in[key_row[3*k +: 3]] = 1'b0;
         end
      end
   end
endmodule : kms_keypad

// >>> verification/kms_chk.sv
// Port checker for the keypad matrix scanner.
// Assumes it is bound into every scanner instance.
`timescale 1ns/1ps
module kms_chk
   import kms_pkg::*;
#(
   parameter int HALF_CYCLES = KCLK_HALF_CYCLES
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Keypad side.
   input wire logic kclk_run,
   input wire logic [5:0] sense_in,
   input wire logic [4:0] drive_out,
   input wire logic key_irq
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   logic auto_q, en_q, man_q; // Shadow mode bits; man_q trusts drv_q.
   logic [4:0] drv_q; // Shadow drive register.
   logic [5:0] size_q; // Shadow size register.
   logic [7:0] lo_q; // Shadow low scan order.
   logic [6:0] hi_q; // Shadow high scan order.
   logic [2:0] quiet_q; // Cycles the sense pins have held still.
   logic [2:0] cnt, slot; // Working values for the slot mask.
   logic [4:0] allow; // Drive lines that the scan may select.
   // Shadows software writes so outputs can be judged.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         {auto_q, en_q, man_q} <= 3'b001;
         drv_q <= RST_DRIVE;
         size_q <= RST_SIZE;
         lo_q <= RST_ORDER_LO;
         hi_q <= RST_ORDER_HI;
      end else if (reg_wr) begin
         if (reg_addr == OFF_STATUS) begin
            auto_q <= reg_wdata[BIT_AUTO];
            en_q <= reg_wdata[BIT_IRQ_EN];
            man_q <= man_q && !reg_wdata[BIT_AUTO];
         end
         if (reg_addr == OFF_DRIVE) begin
            drv_q <= reg_wdata[4:0];
            man_q <= !auto_q;
         end
         if (reg_addr == OFF_SIZE) size_q <= reg_wdata[5:0];
         if (reg_addr == OFF_ORDER_LO) lo_q <= reg_wdata;
         if (reg_addr == OFF_ORDER_HI) hi_q <= reg_wdata[6:0];
      end
   end
   // Counts quiet cycles on the pins, saturating at seven.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         quiet_q <= 3'h0;
      end else begin
         quiet_q <= !$stable(sense_in) ? 3'h0 : quiet_q + 3'(quiet_q != 7);
      end
   end
   // Marks the lines named in the slots that the count lets run.
   always_comb begin
      allow = 5'h00;
      slot = 3'h0;
      cnt = size_q[2:0];
      if (cnt == 3'h0 || cnt > MAX_DRIVE) cnt = MAX_DRIVE;
      for (int i = 0; i < 5; i++) begin
         slot = 3'({hi_q, lo_q} >> (3 * i));
         if (i < cnt && slot < 3'h5) allow[slot] = 1'b1;
      end
   end
   sequence s_stat_rd;
      reg_rd && reg_addr == OFF_STATUS;
   endsequence
   sequence s_fall;
      !auto_q && en_q && $past(sense_in) == 6'h3f && sense_in != 6'h3f;
   endsequence
   a_status_bits: assert property (s_stat_rd |=> reg_rdata[7:4] == 4'h0 &&
      reg_rdata[BIT_AUTO] == $past(auto_q) &&
      reg_rdata[BIT_IRQ_EN] == $past(en_q)) else $error("status read bad");
   a_irq_gated: assert property (!en_q |=> !key_irq)
      else $error("interrupt raised while disabled");
   a_read_clears: assert property (s_stat_rd ##0
      (!auto_q && quiet_q == 3'h7) |=> !key_irq) else $error("flag kept");
   a_manual_detect: assert property (s_fall |-> ##[1:6] key_irq)
      else $error("manual press not flagged");
   a_manual_drive: assert property (!auto_q && man_q |=>
      drive_out == $past(drv_q)) else $error("drive pins differ");
   a_auto_one_low: assert property (auto_q [*3] |->
      $onehot0(~drive_out)) else $error("several lines driven low");
   a_auto_slot_line: assert property (auto_q [*3] |->
      (~drive_out & ~allow) == 5'h00) else $error("line outside order");
   a_size_readback: assert property (reg_rd && reg_addr == OFF_SIZE |=>
      reg_rdata == {2'h0, $past(size_q)})
      else $error("size read bad");
   a_order_readback: assert property (reg_rd && reg_addr == OFF_ORDER_LO |=>
      reg_rdata == $past(lo_q)) else $error("order read bad");
endmodule : kms_chk
bind kms_scanner kms_chk #(.HALF_CYCLES(HALF_CYCLES)) u_chk (
   .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .kclk_run(kclk_run), .sense_in(sense_in),
   .drive_out(drive_out), .key_irq(key_irq));

// >>> verification/tb_keypad_matrix_scanner.sv
// Self-checking bench for the keypad matrix scanner.
// Assumes a 200 MHz clock and a shortened keypad clock period.
`timescale 1ns/1ps
module tb_keypad_matrix_scanner
   import kms_pkg::*;
;
   logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00; // Register port.
   logic kclk_run = 1'b0, key_irq; // Keypad clock request, interrupt.
   logic [1:0] key_down = 2'b00; // Keys held by the bench.
   logic [5:0] key_row = 6'h00, key_col = 6'h00, sense_in;
   logic [7:0] reg_rdata;
   logic [4:0] drive_out;
   int err_count = 0, samples_checked = 0, cycles = 0;
   // Expected register contents after reset, addresses d0 to d8.
   logic [7:0] rst_val [9] = '{8'h00, 8'h1f, 8'h3f, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00};
   // Writable bits per address; the status register is tested apart.
   logic [7:0] wmask [9] = '{8'h00, 8'h1f, 8'h00, 8'hff, 8'h00, 8'h3f,
      8'hff, 8'h7f, 8'h00};
   always #2.5 core_clk = ~core_clk;
   kms_scanner #(.HALF_CYCLES(4)) DUT (.core_clk(core_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .kclk_run(kclk_run),
      .sense_in(sense_in), .drive_out(drive_out), .key_irq(key_irq));
   kms_keypad u_pad (.key_down(key_down), .key_row(key_row),
      .key_col(key_col), .drive_out(drive_out), .sense_in(sense_in));
   // Pattern that a detected key leaves in the drive register.
   function automatic logic [7:0] exp_drive(input logic [2:0] col);
      return 8'h1f & ~(8'h01 << col);
   endfunction : exp_drive
   // Pattern that a detected key leaves in the sense register.
   function automatic logic [7:0] exp_sense(input logic [2:0] row);
      return 8'h3f & ~(8'h01 << row);
   endfunction : exp_sense
   // Compares one value and counts it.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // One write cycle.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // One read cycle; data is taken in the answer cycle.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd
   // Reads and compares; the running keypad clock bit is masked off.
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk(a == OFF_STATUS ? d & 8'hf7 : d, e);
   endtask : rc
   // Waits a bounded time for the interrupt, then checks its level.
   task automatic wait_irq(input int n, input logic v);
      int i = 0;
      while (i < n && key_irq !== 1'b1) begin
         @(posedge core_clk);
         #1;
         i++;
      end
      chk({7'h00, key_irq}, {7'h00, v});
   endtask : wait_irq
   // Sets up a scan, presses one key and checks what is found.
   task automatic auto_key(input logic [2:0] dc, sc, row, slot,
      input logic rev, hit);
      logic [14:0] ord;
      logic [2:0] col;
      for (int i = 0; i < 5; i++) begin
         ord[3*i +: 3] = rev ? 3'(4 - i) : 3'(i);
      end
      col = ord[3*slot +: 3];
      wr(OFF_STATUS, 8'h00);
      wr(OFF_SIZE, {2'h0, sc, dc});
      wr(OFF_ORDER_LO, ord[7:0]);
      wr(OFF_ORDER_HI, {1'b0, ord[14:8]});
      wr(OFF_STATUS, 8'h05);
      @(posedge core_clk);
      key_row <= {3'h0, row};
      key_col <= {3'h0, col};
      key_down <= 2'b01;
      wait_irq(hit ? 3000 : 600, hit);
      if (hit) begin
         rc(OFF_DRIVE, exp_drive(col));
         rc(OFF_SENSE, exp_sense(row));
         rc(OFF_STATUS, 8'h07);
      end
      @(posedge core_clk);
      key_down <= 2'b00;
      repeat (100) @(posedge core_clk);
   endtask : auto_key
   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out
   // Cuts a hang short.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_count++;
         close_out();
      end
   end
   // Main sequence: reset values, registers, clock bit, manual, auto.
   initial begin
      logic [7:0] v;
      logic [2:0] dc, sc;
      logic [1:0] seen;
      v = 8'($urandom(32'hd074));
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      for (int i = 0; i < 9; i++) rc(8'hd0 + 8'(i), rst_val[i]);
      for (int i = 0; i < 9; i++) begin
         if (i != 4) begin
            v = 8'($urandom);
            wr(8'hd0 + 8'(i), v);
            rc(8'hd0 + 8'(i),
               (v & wmask[i]) | (i == 2 ? 8'h3f : 8'h00));
            if (i == 1) chk({3'h0, drive_out}, v & 8'h1f);
         end
      end
      v = 8'($urandom) & 8'hfb;
      wr(OFF_STATUS, v);
      rc(OFF_STATUS, v & 8'h01);
      @(posedge core_clk);
      kclk_run <= 1'b1;
      seen = 2'b00;
      repeat (12) begin
         rd(OFF_STATUS, v);
         seen[v[BIT_CLK]] = 1'b1;
      end
      chk({6'h00, seen}, 8'h03);
      @(posedge core_clk);
      kclk_run <= 1'b0;
      wr(OFF_DRIVE, 8'h00);
      wr(OFF_SIZE, 8'h09);
      wr(OFF_STATUS, 8'h01);
      @(posedge core_clk);
      key_row <= {3'($urandom_range(0, 4)), 3'h5};
      key_col <= {3'($urandom_range(0, 4)), 3'($urandom_range(0, 4))};
      key_down <= 2'b01;
      wait_irq(20, 1'b1);
      rc(OFF_STATUS, 8'h03);
      rc(OFF_STATUS, 8'h01);
      chk({7'h00, key_irq}, 8'h00);
      @(posedge core_clk);
      key_down <= 2'b11;
      wait_irq(20, 1'b0);
      @(posedge core_clk);
      key_down <= 2'b00;
      wr(OFF_STATUS, 8'h00);
      repeat (4) @(posedge core_clk);
      key_down <= 2'b10;
      wait_irq(20, 1'b0);
      rc(OFF_STATUS, 8'h02);
      @(posedge core_clk);
      key_down <= 2'b00;
      wr(OFF_TIMING, 8'h05);
      kclk_run <= 1'b1;
      auto_key(3'h5, 3'h6, 3'h5, 3'h4, 1'b0, 1'b1);
      auto_key(3'h0, 3'h0, 3'h5, 3'h4, 1'b1, 1'b1);
      repeat (3) begin
         dc = 3'($urandom_range(1, 5));
         sc = 3'($urandom_range(1, 6));
         auto_key(dc, sc, 3'($urandom_range(0, sc - 1)),
            3'($urandom_range(0, dc - 1)), 1'($urandom), 1'b1);
      end
      auto_key(3'h4, 3'h6, 3'h2, 3'h4, 1'b0, 1'b0);
      auto_key(3'h5, 3'h5, 3'h5, 3'h1, 1'b1, 1'b0);
      close_out();
   end
endmodule : tb_keypad_matrix_scanner
